// *** scss_pkg.sv ***
// Constants shared by the smart card session sequencer and its testbench.
// Assumes a single 100 MHz system clock domain.
package scss_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Sequencer tick period in ns, from the divided system clock
  localparam int unsigned SEQ_TICK_NS = 400;
  localparam int unsigned SEQ_DIV = (SEQ_TICK_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SEQ_DIV_LAST = 8'(SEQ_DIV - 1);
  // Last tick count of an activation or deactivation step, which lasts five ticks
  localparam logic [3:0] STEP_TICKS = 4'h4;
  localparam logic [3:0] STEP_ZERO = 4'h0;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  // Interrupt event bit positions
  localparam int unsigned EV_ACT_DONE = 0;
  localparam int unsigned EV_DEACT_DONE = 1;
  localparam int unsigned EV_EMERG = 2;
  localparam int unsigned EV_REMOVED = 3;
  localparam int unsigned EV_W = 4;
  localparam logic [3:0] EV_ZERO = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  typedef enum logic [2:0] {
    SCSS_IDLE, SCSS_BOOST, SCSS_VCC, SCSS_ATR, SCSS_SESSION, SCSS_STOP_IO, SCSS_STOP_VCC, SCSS_STOP_BOOST
  } scss_state_t;
endpackage

// *** scss_sync.sv ***
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a pin outside the SYS_CLK domain.
`timescale 1ns/1ns
`default_nettype none
module scss_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic meta;
    logic sync;
  } scss_sync_t;
  scss_sync_t r;
  scss_sync_t next_r;
  always_comb begin
    next_r = r;
    next_r.meta = d;
    next_r.sync = r.meta;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign q = r.sync;
endmodule // scss_sync
`default_nettype wire

// *** scss_top.sv ***
// Smart card activation and deactivation sequencer with supervision.
// Assumes pins are asynchronous; interrupt status over a plain register port.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module scss_top #(
  parameter bit CARD_PRESENT_IN_ACTIVE_HIGH = 1'b1,
  parameter bit ALARM_ACTIVE_HIGH = 1'b0,
  parameter bit BOOST_TRIPLER = 1'b0
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Supervisor and pins
  input wire logic SUPPLY_ALARM,
  input wire logic EXT_RESET,
  input wire logic CARD_PRESENT_IN,
  input wire logic HW_FAULT,
  input wire logic POWER_REDUCED,
  // Controller lines
  input wire logic ACTIVATION_REQUEST_LINE,
  input wire logic RESET_REQUEST_LINE,
  input wire logic CARD_CLK_SRC,
  input wire logic CARD_IO_OUT,
  output logic OFF_STATUS_LINE,
  output logic CTRL_RESET,
  // Alarm pin, open drain
  output logic ALARM_OUT,
  output logic ALARM_OE,
  // Card contacts
  output logic CARD_VCC_EN,
  output logic CARD_CLK,
  output logic CARD_RST,
  output logic CARD_IO,
  output logic LOW_IMPEDANCE_SUPPLY,
  output logic BOOST_EN,
  output logic BOOST_TRIPLE,
  // Register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic IRQ
);
  import scss_pkg::*;

  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_STATE = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic alarm_s, ext_rst_s, card_present_in_s, fault_s, act_s, rstreq_s, clksrc_s, io_s;
  scss_sync u_alarm (.clk(SYS_CLK), .rst(SYS_RST), .d(SUPPLY_ALARM), .q(alarm_s));
  scss_sync u_extr (.clk(SYS_CLK), .rst(SYS_RST), .d(EXT_RESET), .q(ext_rst_s));
  scss_sync u_card_present_in (.clk(SYS_CLK), .rst(SYS_RST), .d(CARD_PRESENT_IN), .q(card_present_in_s));
  scss_sync u_fault (.clk(SYS_CLK), .rst(SYS_RST), .d(HW_FAULT), .q(fault_s));
  scss_sync u_act (.clk(SYS_CLK), .rst(SYS_RST), .d(ACTIVATION_REQUEST_LINE), .q(act_s));
  scss_sync u_rreq (.clk(SYS_CLK), .rst(SYS_RST), .d(RESET_REQUEST_LINE), .q(rstreq_s));
  scss_sync u_csrc (.clk(SYS_CLK), .rst(SYS_RST), .d(CARD_CLK_SRC), .q(clksrc_s));
  scss_sync u_io (.clk(SYS_CLK), .rst(SYS_RST), .d(CARD_IO_OUT), .q(io_s));

  // POWER_REDUCED is accepted but gates nothing: supervision never sleeps
  logic unused_pr;
  assign unused_pr = POWER_REDUCED;

  logic present;
  assign present = CARD_PRESENT_IN_ACTIVE_HIGH ? card_present_in_s : ~card_present_in_s;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    scss_state_t st;
    logic [7:0] div;
    logic tick;
    logic [3:0] steps;
    logic emerg;
    logic act_q;
    logic card_present_in_q;
    logic [3:0] status;
    logic [3:0] mask;
    logic [7:0] rdata;
    logic off;
    logic ctrl_rst;
    logic alarm_out;
    logic alarm_oe;
    logic vcc;
    logic cclk;
    logic crst;
    logic cio;
    logic low_impedance_supply;
    logic boost;
    logic triple;
    logic irq;
  } scss_reg_t;

  scss_reg_t r;
  scss_reg_t next_r;

  logic fault_cond;
  logic step_done;
  logic in_session;
  logic [3:0] ev;

  always_comb begin
    next_r = r;
    ev = EV_ZERO;
    // Divided sequencer tick, one-cycle enable
    next_r.tick = 1'b0;
    if (r.div == SEQ_DIV_LAST) begin
      next_r.div = DIV_ZERO;
      next_r.tick = 1'b1;
    end else begin
      next_r.div = r.div + 8'h01;
    end
    step_done = r.tick && (r.steps == STEP_TICKS);
    if (r.tick) begin
      next_r.steps = (r.steps == STEP_TICKS) ? STEP_ZERO : r.steps + 4'h1;
    end
    next_r.act_q = act_s;
    next_r.card_present_in_q = present;
    in_session = (r.st == SCSS_BOOST) || (r.st == SCSS_VCC) || (r.st == SCSS_ATR) || (r.st == SCSS_SESSION);
    // Removal, supply drop, or fault; checked regardless of power mode
    fault_cond = ~present || alarm_s || fault_s;

    case (r.st)
      SCSS_IDLE: begin
        next_r.steps = STEP_ZERO;
        // Rising edge of request only, so a held line does not restart
        if (act_s && !r.act_q && present && !alarm_s) begin
          next_r.st = SCSS_BOOST;
          next_r.emerg = 1'b0;
        end
      end
      SCSS_BOOST: begin
        if (step_done) begin
          next_r.st = SCSS_VCC;
        end
      end
      SCSS_VCC: begin
        if (step_done) begin
          next_r.st = SCSS_ATR;
        end
      end
      SCSS_ATR: begin
        if (step_done) begin
          next_r.st = SCSS_SESSION;
          ev[EV_ACT_DONE] = 1'b1;
        end
      end
      SCSS_SESSION: begin
        if (!act_s) begin
          next_r.st = SCSS_STOP_IO;
          next_r.steps = STEP_ZERO;
        end
      end
      SCSS_STOP_IO: begin
        if (step_done) begin
          next_r.st = SCSS_STOP_VCC;
        end
      end
      SCSS_STOP_VCC: begin
        if (step_done) begin
          next_r.st = SCSS_STOP_BOOST;
        end
      end
      SCSS_STOP_BOOST: begin
        if (step_done) begin
          next_r.st = SCSS_IDLE;
          ev[EV_DEACT_DONE] = 1'b1;
        end
      end
      default: begin
        next_r.st = SCSS_IDLE;
      end
    endcase
    if (in_session && fault_cond) begin
      next_r.st = SCSS_STOP_IO;
      next_r.steps = STEP_ZERO;
      next_r.emerg = 1'b1;
      ev[EV_EMERG] = 1'b1;
    end
    if (r.card_present_in_q && !present) begin
      ev[EV_REMOVED] = 1'b1;
    end

    // Contact drive per state; alarm blanks everything
    next_r.boost = (r.st != SCSS_IDLE) && (next_r.st != SCSS_IDLE);
    next_r.vcc = (next_r.st == SCSS_VCC) || (next_r.st == SCSS_ATR) || (next_r.st == SCSS_SESSION)
      || (next_r.st == SCSS_STOP_IO);
    // Deactivation only switches things off: after an alarm or an early fault
    // the card must not be powered again on the way down
    if (next_r.st == SCSS_STOP_IO || next_r.st == SCSS_STOP_VCC || next_r.st == SCSS_STOP_BOOST) begin
      next_r.vcc = next_r.vcc && r.vcc;
      next_r.boost = next_r.boost && r.boost;
    end
    // Clamp released as supply rises, held off until the booster has stopped
    next_r.low_impedance_supply = ~(next_r.vcc || (!r.low_impedance_supply && next_r.boost));
    if (next_r.st == SCSS_ATR || next_r.st == SCSS_SESSION) begin
      next_r.cclk = rstreq_s ? 1'b0 : clksrc_s;
      next_r.crst = ~rstreq_s;
      next_r.cio = (next_r.st == SCSS_SESSION) ? io_s : 1'b1;
    end else begin
      next_r.cclk = 1'b0;
      next_r.crst = 1'b0;
      next_r.cio = 1'b0;
    end
    if (alarm_s) begin
      next_r.vcc = 1'b0;
      next_r.cclk = 1'b0;
      next_r.crst = 1'b0;
      next_r.cio = 1'b0;
      next_r.boost = 1'b0;
      next_r.low_impedance_supply = 1'b1;
    end
    next_r.triple = BOOST_TRIPLER;
    // Off line: card present and no emergency pending
    next_r.off = present && !(next_r.emerg);
    next_r.ctrl_rst = alarm_s || ext_rst_s;
    // Open drain: only low is driven, on alarm when active low, while clear when active high
    next_r.alarm_oe = ALARM_ACTIVE_HIGH ? 1'b0 : alarm_s;
    next_r.alarm_out = ALARM_ACTIVE_HIGH ? 1'b1 : 1'b0;
    if (ALARM_ACTIVE_HIGH) begin
      next_r.alarm_oe = ~alarm_s;
      next_r.alarm_out = 1'b0;
    end

    // Register port; set beats write-one-to-clear
    next_r.rdata = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_STATUS: next_r.rdata = {4'h0, r.status};
        ADDR_MASK: next_r.rdata = {4'h0, r.mask};
        ADDR_STATE: next_r.rdata = {2'b00, r.emerg, present, 1'b0, r.st};
        default: next_r.rdata = 8'h00;
      endcase
    end
    if (REG_WR && REG_ADDR == ADDR_STATUS) begin
      next_r.status = r.status & ~REG_WDATA[3:0];
    end
    if (REG_WR && REG_ADDR == ADDR_MASK) begin
      next_r.mask = REG_WDATA[3:0];
    end
    next_r.status = next_r.status | ev;
    next_r.irq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      r <= '0;
      r.low_impedance_supply <= 1'b1;
      r.mask <= MASK_RESET;
      r.st <= SCSS_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign OFF_STATUS_LINE = r.off;
  assign CTRL_RESET = r.ctrl_rst;
  assign ALARM_OUT = r.alarm_out;
  assign ALARM_OE = r.alarm_oe;
  assign CARD_VCC_EN = r.vcc;
  assign CARD_CLK = r.cclk;
  assign CARD_RST = r.crst;
  assign CARD_IO = r.cio;
  assign LOW_IMPEDANCE_SUPPLY = r.low_impedance_supply;
  assign BOOST_EN = r.boost;
  assign BOOST_TRIPLE = r.triple;
  assign REG_RDATA = r.rdata;
  assign IRQ = r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_alarm_blanks_vcc: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    alarm_s |=> !CARD_VCC_EN && !CARD_CLK && !CARD_RST) else $error("contacts active under alarm");
  a_req_ignored_absent: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (r.st == SCSS_IDLE && !present) |=> r.st == SCSS_IDLE) else $error("activation without card");
  a_boost_before_vcc: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(CARD_VCC_EN) |-> $past(BOOST_EN)) else $error("vcc before booster");
  a_clamp_vs_vcc: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CARD_VCC_EN |-> !LOW_IMPEDANCE_SUPPLY) else $error("clamp on while vcc up");
  a_clamp_after_boost: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !BOOST_EN && !CARD_VCC_EN |-> LOW_IMPEDANCE_SUPPLY) else $error("clamp off while idle");
  a_emerg_deact: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (r.st == SCSS_SESSION && fault_cond) |=> r.st == SCSS_STOP_IO) else $error("no emergency stop");
  a_off_falls: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (in_session && fault_cond) |=> !OFF_STATUS_LINE) else $error("off line did not fall");
  a_ctrl_reset: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (alarm_s || ext_rst_s) |=> CTRL_RESET) else $error("controller reset missing");
  a_atr_follow: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (next_r.st == SCSS_ATR && !alarm_s && rstreq_s) |=> !CARD_CLK && !CARD_RST) else $error("atr not following");
  // Contact, state and status properties that must hold whatever order the events arrive in
  a_idle_contacts_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    r.st == SCSS_IDLE |-> !CARD_VCC_EN && !BOOST_EN && !CARD_CLK && !CARD_RST) else $error("idle contacts live");
  a_off_absent: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !present |=> !OFF_STATUS_LINE) else $error("off line high without card");
  a_alarm_pin: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    alarm_s |=> (ALARM_OE != ALARM_ACTIVE_HIGH) && !ALARM_OUT) else $error("alarm pin not asserted");
  a_alarm_deact: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (in_session && alarm_s) |=> r.st == SCSS_STOP_IO) else $error("no deactivation on supply drop");
  a_stop_stays_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (r.st == SCSS_STOP_IO && !CARD_VCC_EN) |=> !CARD_VCC_EN) else $error("card repowered in deactivation");
  a_clamp_fall_vcc: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $fell(LOW_IMPEDANCE_SUPPLY) |-> CARD_VCC_EN) else $error("clamp released before vcc");
  a_clamp_on_stop: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $fell(BOOST_EN) |-> LOW_IMPEDANCE_SUPPLY && !CARD_VCC_EN) else $error("clamp off after booster stop");
  a_alarm_no_start: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (r.st == SCSS_IDLE && alarm_s) |=> r.st == SCSS_IDLE) else $error("activation under alarm");
  a_absent_no_boost: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (r.st == SCSS_IDLE && !present) |=> !BOOST_EN) else $error("booster started without card");
  a_removed_event: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (r.card_present_in_q && !present) |=> r.status[EV_REMOVED]) else $error("removal not recorded");
  a_emerg_flag: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (in_session && fault_cond) |=> r.emerg) else $error("emergency not flagged");
  a_stop_vcc_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    r.st == SCSS_STOP_VCC |-> !CARD_VCC_EN && !CARD_CLK && !CARD_RST) else $error("supply up after io stop");
endmodule // scss_top
`default_nettype wire

// *** scss_card_model.sv ***
// Behavioural smart card seen from the contacts of the sequencer.
// Assumes the bench moves the card in and out with the inserted input.
`timescale 1ns/1ns
`default_nettype none
module scss_card_model #(
  parameter bit CARD_PRESENT_IN_ACTIVE_HIGH = 1'b1
) (
  // Bench control
  input wire logic inserted,
  // Card contacts
  input wire logic vcc_en,
  input wire logic card_clk,
  output logic present_pin,
  // Observation
  output logic [7:0] clk_count
);
  // Presence contact level follows the build-time polarity
  assign present_pin = inserted ? CARD_PRESENT_IN_ACTIVE_HIGH : !CARD_PRESENT_IN_ACTIVE_HIGH;
  // Unpowered card forgets its count, as a real one loses its state
  always @(posedge card_clk or negedge vcc_en) begin
    if (!vcc_en) clk_count <= 8'h00;
    else clk_count <= clk_count + 8'h01;
  end
endmodule // scss_card_model
`default_nettype wire

// *** scss_top_tb.sv ***
// Self-checking bench for the smart card session sequencer.
// Assumes the default build: presence active high, alarm pin active low.
`timescale 1ns/1ns
`default_nettype none
module scss_top_tb;
  import scss_pkg::*;
  logic SYS_CLK, SYS_RST, SUPPLY_ALARM, EXT_RESET, HW_FAULT, POWER_REDUCED;
  logic ACTIVATION_REQUEST_LINE, RESET_REQUEST_LINE, CARD_CLK_SRC, CARD_IO_OUT;
  logic OFF_STATUS_LINE, CTRL_RESET, ALARM_OUT, ALARM_OE, CARD_VCC_EN, CARD_CLK, CARD_RST, CARD_IO;
  logic LOW_IMPEDANCE_SUPPLY, BOOST_EN, BOOST_TRIPLE, REG_WR, REG_RD, IRQ, inserted, card_present_in;
  logic [3:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA, clk_count, d;
  int fail_count = 0;
  int total_checks = 0;
  scss_top i_scss_top (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SUPPLY_ALARM(SUPPLY_ALARM),
    .EXT_RESET(EXT_RESET), .CARD_PRESENT_IN(card_present_in), .HW_FAULT(HW_FAULT), .POWER_REDUCED(POWER_REDUCED),
    .ACTIVATION_REQUEST_LINE(ACTIVATION_REQUEST_LINE), .RESET_REQUEST_LINE(RESET_REQUEST_LINE),
    .CARD_CLK_SRC(CARD_CLK_SRC), .CARD_IO_OUT(CARD_IO_OUT), .OFF_STATUS_LINE(OFF_STATUS_LINE),
    .CTRL_RESET(CTRL_RESET), .ALARM_OUT(ALARM_OUT), .ALARM_OE(ALARM_OE), .CARD_VCC_EN(CARD_VCC_EN),
    .CARD_CLK(CARD_CLK), .CARD_RST(CARD_RST), .CARD_IO(CARD_IO), .LOW_IMPEDANCE_SUPPLY(LOW_IMPEDANCE_SUPPLY),
    .BOOST_EN(BOOST_EN), .BOOST_TRIPLE(BOOST_TRIPLE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
  scss_card_model i_scss_card_model (.inserted(inserted), .vcc_en(CARD_VCC_EN), .card_clk(CARD_CLK),
    .present_pin(card_present_in), .clk_count(clk_count));
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return BOOST_EN;
      1: return CARD_VCC_EN;
      2: return OFF_STATUS_LINE;
      default: return LOW_IMPEDANCE_SUPPLY;
    endcase
  endfunction
  // Bounded poll so a stuck sequencer shows as a mismatch, not a hang
  task automatic wait_sig(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge SYS_CLK);
      #1 n++;
    end
    chk("wait", {7'h0, sig(k)}, {7'h0, v});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= v;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      CARD_CLK_SRC <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      CARD_CLK_SRC <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
    end
  endtask
  task automatic activate();
    int n;
    @(posedge SYS_CLK);
    RESET_REQUEST_LINE <= 1'b1;
    ACTIVATION_REQUEST_LINE <= 1'b1;
    wait_sig(0, 1'b1, 2000);
    chk("vcc_before_boost", CARD_VCC_EN, 8'h0);
    wait_sig(1, 1'b1, 2000);
    chk("boost_at_vcc", BOOST_EN, 8'h1);
    chk("clamp_at_vcc", LOW_IMPEDANCE_SUPPLY, 8'h0);
    for (n = 0; n < 100; n++) begin
      rd(4'h2);
      if (d[2:0] === 3'h4) break;
      repeat (20) @(posedge SYS_CLK);
    end
    chk("state_session", {5'h0, d[2:0]}, 8'h4);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge SYS_CLK);
    fail_count++;
    print_verdict();
  end
  initial begin
    {SUPPLY_ALARM, EXT_RESET, HW_FAULT, POWER_REDUCED, ACTIVATION_REQUEST_LINE} = 5'h0;
    {RESET_REQUEST_LINE, CARD_CLK_SRC, CARD_IO_OUT, REG_WR, REG_RD, inserted} = 6'h0;
    REG_ADDR = 4'h0;
    REG_WDATA = 8'h00;
    SYS_RST = 1'b1;
    repeat (4) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    #1 chk("clamp_rst", LOW_IMPEDANCE_SUPPLY, 8'h1);
    chk("vcc_rst", {CARD_VCC_EN, CARD_CLK, CARD_RST, CARD_IO, BOOST_EN}, 8'h0);
    chk("doubler", BOOST_TRIPLE, 8'h0);
    chk("off_absent", OFF_STATUS_LINE, 8'h0);
    rd(4'h1); chk("mask_rst", d, 8'h00);
    rd(4'h7); chk("unmapped", d, 8'h00);
    wr(4'h1, 8'h00);
    $display("test reset done");
    ACTIVATION_REQUEST_LINE <= 1'b1;
    repeat (1000) @(posedge SYS_CLK);
    #1 chk("boost_absent", BOOST_EN, 8'h0);
    ACTIVATION_REQUEST_LINE <= 1'b0;
    inserted <= 1'b1;
    SUPPLY_ALARM <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    #1 chk("ctrl_rst_alarm", CTRL_RESET, 8'h1);
    chk("alarm_pin", {ALARM_OE, ALARM_OUT}, 8'h2);
    ACTIVATION_REQUEST_LINE <= 1'b1;
    repeat (1000) @(posedge SYS_CLK);
    #1 chk("boost_alarm", BOOST_EN, 8'h0);
    ACTIVATION_REQUEST_LINE <= 1'b0;
    SUPPLY_ALARM <= 1'b0;
    EXT_RESET <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    #1 chk("ctrl_rst_ext", CTRL_RESET, 8'h1);
    EXT_RESET <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    #1 chk("ctrl_rst_free", {CTRL_RESET, ALARM_OE}, 8'h0);
    chk("off_present", OFF_STATUS_LINE, 8'h1);
    $display("test refusal done");
    activate();
    pulses(3);
    chk("clk_held", {CARD_CLK, CARD_RST}, 8'h0);
    chk("no_pulses", clk_count, 8'h0);
    RESET_REQUEST_LINE <= 1'b0;
    pulses(8);
    chk("atr_pulses", clk_count, 8'h8);
    CARD_IO_OUT <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    #1 chk("io_follow", CARD_IO, 8'h1);
    rd(4'h0); chk("act_done", d & 8'h01, 8'h01);
    wr(4'h0, 8'hFF);
    ACTIVATION_REQUEST_LINE <= 1'b0;
    wait_sig(3, 1'b1, 3000);
    chk("deact_off", {CARD_VCC_EN, BOOST_EN}, 8'h0);
    chk("off_normal", OFF_STATUS_LINE, 8'h1);
    rd(4'h0); chk("deact_done", d & 8'h02, 8'h02);
    $display("test session done");
    activate();
    inserted <= 1'b0;
    wait_sig(2, 1'b0, 3000);
    wait_sig(3, 1'b1, 3000);
    chk("removed_vcc", {CARD_VCC_EN, BOOST_EN}, 8'h0);
    chk("irq_masked", IRQ, 8'h0);
    rd(4'h0); chk("emerg_bits", d & 8'h0C, 8'h0C);
    wr(4'h1, 8'h0F);
    rd(4'h1); chk("mask_wr", d, 8'h0F);
    repeat (2) @(posedge SYS_CLK);
    #1 chk("irq_set", IRQ, 8'h1);
    wr(4'h0, 8'hFF);
    repeat (2) @(posedge SYS_CLK);
    #1 chk("irq_clear", IRQ, 8'h0);
    wr(4'h1, 8'h00);
    inserted <= 1'b1;
    repeat (1000) @(posedge SYS_CLK);
    #1 chk("no_restart", CARD_VCC_EN, 8'h0);
    ACTIVATION_REQUEST_LINE <= 1'b0;
    $display("test removal done");
    POWER_REDUCED <= 1'b1;
    activate();
    HW_FAULT <= 1'b1;
    wait_sig(2, 1'b0, 3000);
    wait_sig(3, 1'b1, 3000);
    chk("fault_vcc", CARD_VCC_EN, 8'h0);
    HW_FAULT <= 1'b0;
    ACTIVATION_REQUEST_LINE <= 1'b0;
    repeat (10) @(posedge SYS_CLK);
    $display("test fault done");
    activate();
    SUPPLY_ALARM <= 1'b1;
    wait_sig(1, 1'b0, 8);
    chk("alarm_contacts", {CARD_CLK, CARD_RST, CARD_IO}, 8'h0);
    SUPPLY_ALARM <= 1'b0;
    ACTIVATION_REQUEST_LINE <= 1'b0;
    $display("test alarm done");
    print_verdict();
  end
endmodule // scss_top_tb
`default_nettype wire
